// ---- rtl/debug_trace_status_control.v ----
// debug trace status and control: full flag, sequencer state, trace
// enable, trace mode and trigger alignment behind an apb slave
// assumes the core supplies comparator state requests, trace stores,
// secure level and breakpoint events on core_clk
//
// Summary of operation
// - set full flag after 64 stored lines
// - full flag means all 64 lines valid
// - writing session enable one clears full flag
// - full flag cleared only by power-on reset or arming
// - full flag mirrored at line count bit 7
// - state flags follow each sequencer transition
// - software disarm keeps last state flags
// - internal session end returns to state 0
// - arming forces state 1, flags 001
// - state codes 000 to 100, rest reserved
// - trace request writable only unsecured and disarmed
// - mode and alignment writable only when disarmed
// - trace request selects tracing on trigger
// - secured: trace request stays clear, no tracing
// - buffer reads only while trace request set
// - mode 00 stores change of flow
// - mode 01 suppresses redundant flow entries
// - mode 10 stores address and data
// - mode 11 stores program counter
// - alignment chooses trigger end or begin
// - session enable auto-cleared at session end
// - no trace request means no tracing
`include "debug_trace_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module debug_trace_status_control #(
  parameter LINE_W = 6
)(
  input wire core_clk,
  input wire rstn,
  input wire por_n,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // core side
  input wire secure_in,
  input wire [2:0] seq_next_state,
  input wire seq_advance,
  input wire session_end_event,
  input wire breakpoint_event,
  input wire trace_store,
  input wire redundant_entry,
  input wire buf_read_req,
  // outputs to comparators and trace storage
  output reg session_armed,
  output reg trace_enable,
  output reg [1:0] trace_mode_select,
  output reg trigger_alignment,
  output reg trace_write,
  output reg imm_trigger,
  output reg buf_read_enable,
  output reg all_lines_valid,
  output reg [LINE_W:0] trace_line_count
);

  // ==========================================================
  // secure input synchroniser
  reg sec_s1;
  reg sec_s2;
  reg sec_s3;
  reg secured;

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sec_s1 <= 1'b1;
      sec_s2 <= 1'b1;
      sec_s3 <= 1'b1;
    end
    else if (clk_en)
    begin
      sec_s1 <= secure_in;
      sec_s2 <= sec_s1;
      sec_s3 <= sec_s2;
    end
  end

  // a change counts once the last two stages agree
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      secured <= 1'b1;
    else if (clk_en && sec_s2 == sec_s3)
      secured <= sec_s3;
  end

  // ==========================================================
  // bus decode
  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `DEBUG_CONTROL_ONE_ADDR) ||
                  (a == `DEBUG_STATUS_ADDR) ||
                  (a == `TRACE_CONTROL_ADDR) ||
                  (a == `TRACE_LINE_COUNT_ADDR);
    end
  endfunction

  wire wr_ctl1 = wr & (paddr == `DEBUG_CONTROL_ONE_ADDR);
  wire wr_tcr = wr & (paddr == `TRACE_CONTROL_ADDR);
  wire arm_write = wr_ctl1 & pwdata[`SESSION_ENABLE_BIT];
  wire disarm_write = wr_ctl1 & ~pwdata[`SESSION_ENABLE_BIT];
  wire trig_write = wr_ctl1 & pwdata[`IMM_TRIGGER_BIT];
  wire tcr_open = wr_tcr & ~session_armed;

  // ==========================================================
  // control registers
  reg break_enable;
  reg [2:0] seq_flags;
  reg buffer_full_flag;
  reg begin_started;

  // internal end: sequence completes or breakpoint without tracing
  wire internal_end = session_armed & (session_end_event |
                      (breakpoint_event & ~trace_enable));

  // ==========================================================
  // session enable
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      session_armed <= 1'b0;
    else if (clk_en)
    begin
      if (wr_ctl1)
        session_armed <= pwdata[`SESSION_ENABLE_BIT];
      else if (internal_end)
        session_armed <= 1'b0;
    end
  end

  // ==========================================================
  // break enable, writable only while disarmed
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      break_enable <= 1'b0;
    else if (clk_en)
    begin
      if (wr_ctl1 && !session_armed)
        break_enable <= pwdata[`BREAK_ENABLE_BIT];
    end
  end

  // ==========================================================
  // immediate trigger pulse
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      imm_trigger <= 1'b0;
    else if (clk_en)
    begin
      // trigger ignored once begin-aligned tracing has started
      imm_trigger <= trig_write & trace_enable & ~secured &
                     ~begin_started;
    end
  end

  // ==========================================================
  // trace request
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      trace_enable <= 1'b0;
    else if (clk_en)
    begin
      if (secured)
        trace_enable <= 1'b0;
      else if (tcr_open)
        trace_enable <= pwdata[`TRACE_REQUEST_BIT];
    end
  end

  // ==========================================================
  // trace mode and trigger alignment
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trace_mode_select <= `MODE_NORMAL;
      trigger_alignment <= 1'b0;
    end
    else if (clk_en)
    begin
      if (tcr_open)
      begin
        trace_mode_select <= pwdata[`TRACE_MODE_HI:`TRACE_MODE_LO];
        trigger_alignment <= pwdata[`TRIGGER_ALIGN_BIT];
      end
    end
  end

  // ==========================================================
  // state sequencer flags
  function is_legal_state;
    input [2:0] s;
    begin
      is_legal_state = (s <= `SEQ_FINAL);
    end
  endfunction

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      seq_flags <= `SEQ_STATE0;
    else if (clk_en)
    begin
      if (arm_write)
        seq_flags <= `SEQ_STATE1;
      else if (disarm_write)
        seq_flags <= seq_flags;
      else if (internal_end)
        seq_flags <= `SEQ_STATE0;
      else if (session_armed && seq_advance &&
               is_legal_state(seq_next_state))
        seq_flags <= seq_next_state;
    end
  end

  // ==========================================================
  // trace storage control
  wire tracing_on = session_armed & trace_enable & ~secured;
  // alignment 1 traces from trigger; 0 traces until trigger
  wire in_window = trigger_alignment ?
                   (seq_flags == `SEQ_FINAL) :
                   (seq_flags != `SEQ_FINAL);
  reg store_ok;

  always @*
  begin
    case (trace_mode_select)
      `MODE_NORMAL: store_ok = 1'b1;
      `MODE_LOOP_SUPPRESS: store_ok = ~redundant_entry;
      `MODE_DETAIL: store_ok = 1'b1;
      `MODE_PC_ONLY: store_ok = 1'b1;
      default: store_ok = 1'b0;
    endcase
  end

  wire do_store = tracing_on & in_window & trace_store & store_ok;

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      trace_write <= 1'b0;
    else if (clk_en)
      trace_write <= do_store;
  end

  // ==========================================================
  // stored line counter, cleared on arming
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      trace_line_count <= {(LINE_W+1){1'b0}};
    else if (clk_en)
    begin
      if (arm_write)
        trace_line_count <= {(LINE_W+1){1'b0}};
      else if (do_store)
        trace_line_count <= {1'b0, trace_line_count[LINE_W-1:0] +
                            {{(LINE_W-1){1'b0}}, 1'b1}};
    end
  end

  // ==========================================================
  // begin-aligned tracing has started
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      begin_started <= 1'b0;
    else if (clk_en)
    begin
      if (arm_write)
        begin_started <= 1'b0;
      else if (do_store)
        begin_started <= trigger_alignment;
    end
  end

  // full flag only sees power-on reset
  wire last_line = do_store &
                   (&trace_line_count[LINE_W-1:0]);

  always @(posedge core_clk or negedge por_n)
  begin
    if (!por_n)
      buffer_full_flag <= 1'b0;
    else if (clk_en)
    begin
      if (last_line)
        buffer_full_flag <= 1'b1;
      else if (arm_write)
        buffer_full_flag <= 1'b0;
    end
  end

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      all_lines_valid <= 1'b0;
    else if (clk_en)
      all_lines_valid <= buffer_full_flag | last_line;
  end

  // buffer reads need trace request, disarmed and unsecured
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      buf_read_enable <= 1'b0;
    else if (clk_en)
      buf_read_enable <= buf_read_req & trace_enable &
                         ~session_armed & ~secured;
  end

  // ==========================================================
  // read data mux, unused bits read zero
  reg [7:0] next_rdata;

  always @*
  begin
    case (paddr)
      `DEBUG_CONTROL_ONE_ADDR:
        next_rdata = {session_armed, 3'h0, break_enable, 3'h0};
      `DEBUG_STATUS_ADDR:
        next_rdata = {buffer_full_flag, 4'h0, seq_flags};
      `TRACE_CONTROL_ADDR:
        next_rdata = {1'b0, trace_enable, 2'h0, trace_mode_select, 1'b0,
                      trigger_alignment};
      `TRACE_LINE_COUNT_ADDR:
        next_rdata = {buffer_full_flag, {(7-LINE_W){1'b0}},
                      trace_line_count[LINE_W-1:0]};
      default:
        next_rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // apb answer: one wait state, registered read data
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      pready <= acc;
      pslverr <= acc & ~is_mapped(paddr);
      prdata <= 32'h00000000;
      if (rd)
        prdata <= {24'h000000, next_rdata};
    end
  end

endmodule // debug_trace_status_control

`default_nettype wire

// ---- rtl/debug_trace_regs.vh ----
// register offsets, field positions, reset values and codes for the
// debug trace status and control block
// assumes a 32-bit apb slave, one register per aligned word
`ifndef DEBUG_TRACE_REGS_VH
`define DEBUG_TRACE_REGS_VH

// printed offsets are register indices; byte address is four times index
`define DEBUG_CONTROL_ONE_IDX 8'h20
`define DEBUG_STATUS_IDX 8'h21
`define TRACE_CONTROL_IDX 8'h22
`define TRACE_LINE_COUNT_IDX 8'h26
`define DEBUG_CONTROL_ONE_ADDR 12'h080
`define DEBUG_STATUS_ADDR 12'h084
`define TRACE_CONTROL_ADDR 12'h088
`define TRACE_LINE_COUNT_ADDR 12'h098

// field positions
`define SESSION_ENABLE_BIT 7
`define IMM_TRIGGER_BIT 6
`define BREAK_ENABLE_BIT 3
`define BUFFER_FULL_BIT 7
`define TRACE_REQUEST_BIT 6
`define TRACE_MODE_HI 3
`define TRACE_MODE_LO 2
`define TRIGGER_ALIGN_BIT 0

// reset values
`define DEBUG_STATUS_RST 8'h00
`define TRACE_CONTROL_RST 8'h00
`define DEBUG_CONTROL_ONE_RST 8'h00

// trace buffer size in lines
`define TRACE_LINES 7'h40

// sequencer state codes
`define SEQ_STATE0 3'h0
`define SEQ_STATE1 3'h1
`define SEQ_STATE2 3'h2
`define SEQ_STATE3 3'h3
`define SEQ_FINAL 3'h4

// trace modes
`define MODE_NORMAL 2'h0
`define MODE_LOOP_SUPPRESS 2'h1
`define MODE_DETAIL 2'h2
`define MODE_PC_ONLY 2'h3

`endif

// ---- verif/core_model.sv ----
// core model: offers a burst of trace lines on request
// assumes core_clk of the block under test
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [6:0] n,
  output var logic trace_store,
  output var logic redundant_entry,
  output var logic busy
);
  // ==========
  // store burst
  logic [6:0] left = 7'h00;
  initial trace_store = 1'b0;
  initial redundant_entry = 1'b0;
  assign busy = left != 7'h00;
  always @(posedge core_clk)
  begin
    trace_store <= 1'b0;
    if (go)
      left <= n;
    else if (busy && !trace_store)
    begin
      left <= left - 7'h01;
      trace_store <= 1'b1;
      redundant_entry <= left[0];
    end
  end
endmodule // core_model
`default_nettype wire

// ---- verif/debug_trace_status_control_checker.sv ----
// assertions on the debug trace status and control ports
// assumes bind to the block's top module
`timescale 1ns/100ps
`default_nettype none
module debug_trace_status_control_checker #(parameter LINE_W = 6) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trace_store,
  input wire logic trace_write,
  input wire logic trace_enable,
  input wire logic session_armed,
  input wire logic [1:0] trace_mode_select,
  input wire logic buf_read_enable
);
  // ==========
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_stat;
    pready && !pwrite && paddr == 12'h084;
  endsequence
  AST_ANSWER: assert property (s_acc |=> pready)
    else $error("access not answered");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_STAT: assert property (s_stat |-> prdata[31:8] == 24'h0 &&
    prdata[6:3] == 4'h0 && prdata[2:0] <= 3'h4)
    else $error("bad status read");
  AST_TW: assert property (trace_write |->
    $past(trace_store && trace_enable && session_armed))
    else $error("line stored without request");
  AST_TREQ: assert property ($rose(trace_enable) |-> !$past(session_armed))
    else $error("trace request set while armed");
  AST_MODE: assert property ($changed(trace_mode_select) |->
    !$past(session_armed))
    else $error("mode changed while armed");
  AST_BUF: assert property (buf_read_enable |->
    trace_enable || $past(trace_enable))
    else $error("buffer read without request");
endmodule // debug_trace_status_control_checker
`default_nettype wire

// ---- verif/debug_trace_status_control_test.sv ----
// bench for the debug trace status and control block
// assumes core_model as core side, apb master tasks here
`timescale 1ns/100ps
`default_nettype none
module debug_trace_status_control_test;
  logic core_clk, rstn, por_n, clk_en, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, secure_in, seq_advance, session_end_event;
  logic [2:0] seq_next_state;
  logic breakpoint_event, trace_store, redundant_entry, buf_read_req;
  logic session_armed, trace_enable, trigger_alignment, trace_write;
  logic [1:0] trace_mode_select;
  logic imm_trigger, buf_read_enable, all_lines_valid, go, busy;
  logic [6:0] trace_line_count, n;
  integer fails = 0, n_compared = 0, i, m;
  debug_trace_status_control dut_u (.*);
  core_model core_u (.*);
  // ==========
  // tasks
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task final_report;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cmp(input string s, input [31:0] e, input [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task xfer(input [11:0] a, input w, input [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge core_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      final_report;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input string s, input [11:0] a, input [31:0] e);
    xfer(a, 1'b0, 8'h00);
    cmp(s, e, q);
  endtask
  task adv(input [2:0] s);
    @(posedge core_clk);
    seq_next_state <= s;
    seq_advance <= 1'b1;
    @(posedge core_clk);
    seq_advance <= 1'b0;
  endtask
  task store(input [6:0] k);
    @(posedge core_clk);
    n <= k;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    for (i = 0; i < 300 && busy !== 1'b0; i++)
      @(posedge core_clk);
    if (busy !== 1'b0)
    begin
      fails++;
      final_report;
    end
    repeat (2) @(posedge core_clk);
  endtask
  // ==========
  // tests
  initial
  begin
    {rstn, por_n, psel, penable, pwrite, paddr, pwdata} = 0;
    {seq_advance, seq_next_state, session_end_event, go, n} = 0;
    {breakpoint_event, buf_read_req, secure_in} = 0;
    clk_en = 1'b1;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd("status", 12'h084, 0);
    rd("trace ctl", 12'h088, 0);
    xfer(12'h0fc, 1'b0, 8'h00);
    cmp("slverr", 1, err);
    xfer(12'h084, 1'b1, 8'hff);
    rd("status ro", 12'h084, 0);
    for (m = 0; m < 4; m++)
    begin
      xfer(12'h088, 1'b1, m << 2);
      cmp("mode", m, trace_mode_select);
    end
    xfer(12'h088, 1'b1, 8'h41);
    rd("trace ctl", 12'h088, 32'h41);
    cmp("align", 1, trigger_alignment);
    xfer(12'h088, 1'b1, 8'h40);
    $display("test config done");
    xfer(12'h080, 1'b1, 8'h80);
    rd("arm", 12'h084, 1);
    xfer(12'h088, 1'b1, 8'h0d);
    rd("locked", 12'h088, 32'h40);
    adv(3'h2);
    rd("state", 12'h084, 2);
    adv(3'h7);
    rd("reserved", 12'h084, 2);
    store(7'h40);
    rd("full", 12'h084, 32'h82);
    xfer(12'h098, 1'b0, 8'h00);
    cmp("count msb", 1, q[7]);
    cmp("all valid", 1, all_lines_valid);
    xfer(12'h080, 1'b1, 8'h00);
    rd("disarm", 12'h084, 32'h82);
    $display("test session done");
    rstn <= 1'b0;
    @(posedge core_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd("sys reset", 12'h084, 32'h80);
    xfer(12'h080, 1'b1, 8'h80);
    rd("rearm", 12'h084, 1);
    store(7'h04);
    cmp("no trace", 0, trace_line_count);
    @(posedge core_clk);
    session_end_event <= 1'b1;
    @(posedge core_clk);
    session_end_event <= 1'b0;
    rd("end state", 12'h084, 0);
    rd("end arm", 12'h080, 0);
    xfer(12'h088, 1'b1, 8'h40);
    secure_in <= 1'b1;
    repeat (8) @(posedge core_clk);
    xfer(12'h088, 1'b1, 8'h40);
    rd("secured", 12'h088, 0);
    secure_in <= 1'b0;
    repeat (8) @(posedge core_clk);
    xfer(12'h088, 1'b1, 8'h40);
    buf_read_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp("buf rd", 1, buf_read_enable);
    xfer(12'h080, 1'b1, 8'h40);
    cmp("imm trig", 1, imm_trigger);
    xfer(12'h088, 1'b1, 8'h44);
    xfer(12'h080, 1'b1, 8'h80);
    store(7'h04);
    cmp("loop count", 2, trace_line_count);
    $display("test secure done");
    final_report;
  end
endmodule // debug_trace_status_control_test
bind debug_trace_status_control debug_trace_status_control_checker
  #(.LINE_W(LINE_W)) chk_u (.*);
`default_nettype wire
